// *** prsc_pkg.sv ***
/*
  Shared types and constants for the pad reset and standby configuration
  block: pad configuration fields, register map, reset values, timing.
  Assumes a single 100 MHz pclk domain and a 12-bit APB byte address.
*/
`default_nettype none

package prsc_pkg;

  // ==========================================================
  // Pad configuration carrier
  // ==========================================================
  typedef struct packed {
    logic [1:0] slew;
    logic out;
    logic pull_up;
    logic pull_en;
    logic ibe;
    logic oe;
  } prsc_pad_cfg_t;

  localparam int CFG_W = 7;
  localparam int CFG_OE_BIT = 0;
  localparam int CFG_IBE_BIT = 1;
  localparam int CFG_PULL_EN_BIT = 2;
  localparam int CFG_PULL_UP_BIT = 3;
  localparam int CFG_OUT_BIT = 4;
  localparam int CFG_SLEW_LSB = 5;

  localparam logic [1:0] SLEW_SLOW = 2'h0;
  localparam logic [1:0] SLEW_MEDIUM = 2'h1;
  localparam logic [1:0] SLEW_FAST = 2'h2;

  localparam prsc_pad_cfg_t PAD_TRISTATE = 7'h00;
  localparam prsc_pad_cfg_t PAD_TRISTATE_MED = 7'h20;
  localparam prsc_pad_cfg_t PAD_IN_PULLUP = 7'h0e;
  localparam prsc_pad_cfg_t PAD_IN_PULLDOWN = 7'h06;
  localparam prsc_pad_cfg_t PAD_IN_NOPULL = 7'h02;
  localparam prsc_pad_cfg_t PAD_DRIVE_LOW = 7'h01;

  // ==========================================================
  // Register map (byte addresses)
  // ==========================================================
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_STATUS = 12'h000;
  localparam logic [11:0] ADDR_WAKE_EN = 12'h004;
  localparam logic [11:0] ADDR_GP_BASE = 12'h010;
  localparam logic [11:0] ADDR_WK_BASE = 12'h040;

  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_BOOT_ALT_BIT = 4;
  localparam int STAT_RST_PAD_BIT = 5;
  localparam int STAT_PHASE3_DONE_BIT = 6;

  // ==========================================================
  // Pad counts, and pad roles inside the general and wake pad groups
  // ==========================================================
  localparam int GP_PADS_DEF = 8;
  localparam int GP_MEDIUM_IDX = 0;
  localparam int GP_PULLUP_LO = 1;
  localparam int GP_PULLUP_HI = 4;
  localparam int WK_PADS_DEF = 4;
  localparam int TRACE_PADS_DEF = 4;
  localparam logic [3:0] WK_NO_STBY_MASK_DEF = 4'h3;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int RC_DIV_DEF = 6;
  localparam int PHASE3_RC_CYCLES = 40;

  typedef enum logic [2:0] {
    ST_POWERUP,
    ST_PHASE2,
    ST_PHASE3,
    ST_RUN,
    ST_STANDBY
  } prsc_state_t;

endpackage

`default_nettype wire

// *** prsc_rc_counter.sv ***
/*
  Counts internal RC oscillator periods while run is high. The oscillator
  is modelled as a one-cycle enable from a divider of pclk. Assumes run
  stays high until done is seen, and drops to restart the count.
*/
`timescale 1ns/100ps
`default_nettype none

module prsc_rc_counter #(
  parameter int DIV = prsc_pkg::RC_DIV_DEF,
  parameter int COUNT = prsc_pkg::PHASE3_RC_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  output logic done
);

  localparam int DW = $clog2(DIV + 1);
  localparam int CW = $clog2(COUNT + 1);
  localparam logic [DW-1:0] DIV_LAST = DW'(DIV - 1);
  localparam logic [CW-1:0] COUNT_LAST = CW'(COUNT);

  typedef struct packed {
    logic [DW-1:0] div;
    logic [CW-1:0] rc;
    logic done;
  } prsc_cnt_state_t;

  prsc_cnt_state_t q;
  prsc_cnt_state_t d;

  always_comb
  begin
    d = q;
    if (!run)
    begin
      d = '0;
    end
    else if (!q.done)
    begin
      if (q.div == DIV_LAST)
      begin
        // One internal RC oscillator period has elapsed
        d.div = '0;
        d.rc = q.rc + CW'(1);
        if (d.rc == COUNT_LAST)
        begin
          d.done = 1'h1; // RULE16
        end
      end
      else
      begin
        d.div = q.div + DW'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign done = q.done;

endmodule

`default_nettype wire

// *** prsc_wake_ctl.sv ***
/*
  Wakeup source qualification for the low-power wake pads. Pins are
  asynchronous and pass two flip-flops. Assumes wake_en and standby come
  from logic on pclk.
*/
`timescale 1ns/100ps
`default_nettype none

module prsc_wake_ctl #(
  parameter int N = prsc_pkg::WK_PADS_DEF,
  parameter logic [N-1:0] NO_STBY_MASK = prsc_pkg::WK_NO_STBY_MASK_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [N-1:0] wake_pin,
  input wire logic [N-1:0] wake_en,
  input wire logic standby,
  output logic wake_hit
);

  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
  } prsc_wake_state_t;

  prsc_wake_state_t q;
  prsc_wake_state_t d;
  logic [N-1:0] allowed;

  always_comb
  begin
    d.s1 = wake_pin;
    d.s2 = q.s1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  // Some sources are cut off only while in standby
  assign allowed = standby ? ~NO_STBY_MASK : {N{1'h1}}; // RULE12
  assign wake_hit = |(q.s2 & wake_en & allowed);

endmodule

`default_nettype wire

// *** prsc_top.sv ***
/*
  Pad configuration through the reset phases and on standby exit, with an
  APB register file for the general and wake pad settings.
  Assumes phase and standby levels come from the reset generator and mode
  logic on pclk; pad pins are asynchronous and are synchronised here.
*/
// Design decisions made here: the placing of the registers and register access over APB.
// Overview of operation
// RULE1: During power-up every pad is tristate, whatever else is set.
// RULE2: After power-up pads stay tristate except the listed special pads.
// RULE3: Boot pad weakly pulled low; board pull-up selects alternate boot.
// RULE4: On reset release the four pull-up pads become inputs with pull-up.
// RULE5: Reset pad driven low until 40 RC cycles after phase 2 ends.
// RULE6: Phase 3 lasts at least 40 RC cycles before sequence proceeds.
// RULE7: After power-up the trace output pads are forced to output.
// RULE8: Wake pads take buffer and pull from pad unit and wakeup unit.
// RULE9: On standby exit wake pads load the wakeup unit settings.
// RULE10: On standby exit all other pads return to their reset configuration.
// RULE11: In standby the test data out pad is an input with no pull.
// RULE12: Two wake sources wake the device in every mode except standby.
// RULE13: Board ties test data out high through 47 to 100 kOhm.
// RULE14: Medium and fast pads reset to slow slew, one pad to medium.
// RULE15: After phase 2 plus 40 RC cycles reset pad is pulled-up input.
// RULE16: RC cycle counter starts at phase 2 end, releases drive at forty.
`timescale 1ns/100ps
`default_nettype none

module prsc_top #(
  parameter int NUM_GP = prsc_pkg::GP_PADS_DEF,
  parameter int NUM_WK = prsc_pkg::WK_PADS_DEF,
  parameter int NUM_TRACE = prsc_pkg::TRACE_PADS_DEF,
  parameter int RC_DIV = prsc_pkg::RC_DIV_DEF,
  parameter logic [NUM_WK-1:0] WK_NO_STBY_MASK =
    prsc_pkg::WK_NO_STBY_MASK_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic power_up_done,
  input wire logic phase2_done,
  input wire logic standby_req,
  output logic phase3_done,
  input wire logic boot_pin_in,
  output prsc_pkg::prsc_pad_cfg_t boot_cfg,
  output logic boot_alt,
  input wire logic rst_pad_in,
  output prsc_pkg::prsc_pad_cfg_t rst_pad_cfg,
  input wire logic [NUM_TRACE-1:0] trace_data,
  output prsc_pkg::prsc_pad_cfg_t [NUM_TRACE-1:0] trace_cfg,
  input wire logic tdo_data,
  output prsc_pkg::prsc_pad_cfg_t tdo_cfg,
  output prsc_pkg::prsc_pad_cfg_t [NUM_GP-1:0] gp_cfg,
  input wire logic [NUM_WK-1:0] wku_ibe,
  input wire logic [NUM_WK-1:0] wku_pull_en,
  input wire logic [NUM_WK-1:0] wake_pin,
  output prsc_pkg::prsc_pad_cfg_t [NUM_WK-1:0] wk_cfg,
  output logic wake_req
);

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    prsc_pkg::prsc_state_t st;
    prsc_pkg::prsc_pad_cfg_t [NUM_GP-1:0] gp;
    prsc_pkg::prsc_pad_cfg_t [NUM_WK-1:0] wk;
    logic [NUM_WK-1:0] wake_en;
    logic boot_s1;
    logic boot_s2;
    logic rst_s1;
    logic rst_s2;
    logic boot_alt;
    logic phase3_done;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    prsc_pkg::prsc_pad_cfg_t boot_cfg;
    prsc_pkg::prsc_pad_cfg_t rst_cfg;
    prsc_pkg::prsc_pad_cfg_t [NUM_TRACE-1:0] trace_cfg;
    prsc_pkg::prsc_pad_cfg_t tdo_cfg;
    prsc_pkg::prsc_pad_cfg_t [NUM_GP-1:0] gp_out;
    prsc_pkg::prsc_pad_cfg_t [NUM_WK-1:0] wk_out;
    logic wake_req;
  } prsc_top_state_t;

  prsc_top_state_t q;
  prsc_top_state_t d;
  logic rc_done;
  logic wake_hit;

  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic prsc_pkg::prsc_pad_cfg_t gp_reset(input int idx);
    prsc_pkg::prsc_pad_cfg_t c;
    c = prsc_pkg::PAD_TRISTATE; // RULE14
    if (idx == prsc_pkg::GP_MEDIUM_IDX)
    begin
      c = prsc_pkg::PAD_TRISTATE_MED; // RULE14
    end
    else if (idx >= prsc_pkg::GP_PULLUP_LO && idx <= prsc_pkg::GP_PULLUP_HI)
    begin
      c = prsc_pkg::PAD_IN_PULLUP; // RULE4
    end
    return c;
  endfunction

  // Word index of an address above a base, or -1 when out of range
  function automatic int word_idx(input logic [11:0] a,
                                  input logic [11:0] base,
                                  input int count);
    logic [11:0] off;
    off = a - base;
    if (a < base || a[1:0] != 2'h0 || int'(off[11:2]) >= count)
    begin
      return -1;
    end
    return int'(off[11:2]);
  endfunction

  // ==========================================================
  // Submodules
  // ==========================================================
  prsc_rc_counter #(
    .DIV(RC_DIV),
    .COUNT(prsc_pkg::PHASE3_RC_CYCLES)
  ) u_rc_counter (
    .pclk(pclk),
    .presetn(presetn),
    .run(q.st == prsc_pkg::ST_PHASE3),
    .done(rc_done)
  );

  prsc_wake_ctl #(
    .N(NUM_WK),
    .NO_STBY_MASK(WK_NO_STBY_MASK)
  ) u_wake_ctl (
    .pclk(pclk),
    .presetn(presetn),
    .wake_pin(wake_pin),
    .wake_en(q.wake_en),
    .standby(q.st == prsc_pkg::ST_STANDBY),
    .wake_hit(wake_hit)
  );

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb
  begin
    int gi;
    int wi;
    gi = word_idx(paddr, prsc_pkg::ADDR_GP_BASE, NUM_GP);
    wi = word_idx(paddr, prsc_pkg::ADDR_WK_BASE, NUM_WK);
    d = q;
    d.boot_s1 = boot_pin_in;
    d.boot_s2 = q.boot_s1;
    d.rst_s1 = rst_pad_in;
    d.rst_s2 = q.rst_s1;
    d.wake_req = wake_hit;

    // Phase sequencing
    unique case (q.st)
      prsc_pkg::ST_POWERUP:
      begin
        if (power_up_done)
        begin
          d.st = prsc_pkg::ST_PHASE2;
          // Strap caught once, as the pull-down takes effect
          d.boot_alt = q.boot_s2; // RULE3
        end
      end
      prsc_pkg::ST_PHASE2:
      begin
        if (phase2_done)
        begin
          d.st = prsc_pkg::ST_PHASE3; // RULE16
        end
      end
      prsc_pkg::ST_PHASE3:
      begin
        if (rc_done)
        begin
          d.st = prsc_pkg::ST_RUN; // RULE6
          d.phase3_done = 1'h1; // RULE6
        end
      end
      prsc_pkg::ST_RUN:
      begin
        if (standby_req)
        begin
          d.st = prsc_pkg::ST_STANDBY;
        end
      end
      prsc_pkg::ST_STANDBY:
      begin
        if (!standby_req)
        begin
          d.st = prsc_pkg::ST_RUN;
        end
      end
    endcase

    // APB: one wait state so read data comes from a flop
    if (q.pready)
    begin
      d.pready = 1'h0;
      d.pslverr = 1'h0;
      if (psel && penable && pwrite && !q.pslverr)
      begin
        if (paddr == prsc_pkg::ADDR_WAKE_EN)
        begin
          d.wake_en = pwdata[NUM_WK-1:0];
        end
        else if (gi >= 0)
        begin
          d.gp[gi] = pwdata[prsc_pkg::CFG_W-1:0];
        end
        else if (wi >= 0)
        begin
          d.wk[wi] = pwdata[prsc_pkg::CFG_W-1:0];
        end
      end
    end
    else if (psel && penable)
    begin
      d.pready = 1'h1;
      d.prdata = 32'h0000_0000;
      if (paddr == prsc_pkg::ADDR_STATUS)
      begin
        d.prdata[prsc_pkg::STAT_STATE_LSB +: 3] = q.st;
        d.prdata[prsc_pkg::STAT_BOOT_ALT_BIT] = q.boot_alt;
        d.prdata[prsc_pkg::STAT_RST_PAD_BIT] = q.rst_s2;
        d.prdata[prsc_pkg::STAT_PHASE3_DONE_BIT] = q.phase3_done;
      end
      else if (paddr == prsc_pkg::ADDR_WAKE_EN)
      begin
        d.prdata[NUM_WK-1:0] = q.wake_en;
      end
      else if (gi >= 0)
      begin
        d.prdata[prsc_pkg::CFG_W-1:0] = q.gp[gi];
      end
      else if (wi >= 0)
      begin
        d.prdata[prsc_pkg::CFG_W-1:0] = q.wk[wi];
      end
      else
      begin
        d.pslverr = 1'h1;
      end
    end

    // Standby exit overrides a software write in the same cycle
    if (q.st == prsc_pkg::ST_STANDBY && !standby_req)
    begin
      for (int i = 0; i < NUM_GP; i++)
      begin
        d.gp[i] = gp_reset(i); // RULE10
      end
      for (int i = 0; i < NUM_WK; i++)
      begin
        d.wk[i].ibe = wku_ibe[i]; // RULE9
        d.wk[i].pull_en = wku_pull_en[i]; // RULE9
      end
    end

    // Pad outputs, from the next phase
    if (d.st == prsc_pkg::ST_POWERUP)
    begin
      // Everything floats until supplies are good
      d.boot_cfg = prsc_pkg::PAD_TRISTATE; // RULE1
      d.rst_cfg = prsc_pkg::PAD_TRISTATE; // RULE1
      d.tdo_cfg = prsc_pkg::PAD_TRISTATE; // RULE1
      d.trace_cfg = '0; // RULE1
      d.gp_out = '0; // RULE1
      d.wk_out = '0; // RULE1
    end
    else
    begin
      d.boot_cfg = prsc_pkg::PAD_IN_PULLDOWN; // RULE3
      for (int i = 0; i < NUM_TRACE; i++)
      begin
        d.trace_cfg[i] = prsc_pkg::PAD_TRISTATE;
        d.trace_cfg[i].oe = 1'h1; // RULE7
        d.trace_cfg[i].out = trace_data[i]; // RULE7
      end
      d.gp_out = d.gp; // RULE2 RULE4
      d.wk_out = d.wk;
      if (d.st == prsc_pkg::ST_PHASE2 || d.st == prsc_pkg::ST_PHASE3)
      begin
        d.rst_cfg = prsc_pkg::PAD_DRIVE_LOW; // RULE5
      end
      else
      begin
        d.rst_cfg = prsc_pkg::PAD_IN_PULLUP; // RULE15
      end
      if (d.st == prsc_pkg::ST_STANDBY)
      begin
        // Keeps the debug handshake input alive; the board holds the level
        d.tdo_cfg = prsc_pkg::PAD_IN_NOPULL; // RULE11 RULE13
        for (int i = 0; i < NUM_WK; i++)
        begin
          d.wk_out[i].ibe = wku_ibe[i]; // RULE8
          d.wk_out[i].pull_en = wku_pull_en[i]; // RULE8
        end
      end
      else
      begin
        d.tdo_cfg = prsc_pkg::PAD_TRISTATE;
        d.tdo_cfg.oe = 1'h1;
        d.tdo_cfg.out = tdo_data;
      end
    end
  end

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= '0;
      q.st <= prsc_pkg::ST_POWERUP;
      for (int i = 0; i < NUM_GP; i++)
      begin
        q.gp[i] <= gp_reset(i); // RULE14
      end
    end
    else
    begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign phase3_done = q.phase3_done;
  assign boot_cfg = q.boot_cfg;
  assign boot_alt = q.boot_alt;
  assign rst_pad_cfg = q.rst_cfg;
  assign trace_cfg = q.trace_cfg;
  assign tdo_cfg = q.tdo_cfg;
  assign gp_cfg = q.gp_out;
  assign wk_cfg = q.wk_out;
  assign wake_req = q.wake_req;

endmodule

`default_nettype wire

// *** prsc_board.sv ***
/*
  Board model at the pads: boot strap, reset pad pull-up, test data out
  pull-up. Assumes pad cfgs come from the pad block under test.
*/
`timescale 1ns/100ps
`default_nettype none

module prsc_board (
  input wire logic alt_strap,
  input wire prsc_pkg::prsc_pad_cfg_t boot_cfg,
  input wire prsc_pkg::prsc_pad_cfg_t rst_pad_cfg,
  input wire prsc_pkg::prsc_pad_cfg_t tdo_cfg,
  input wire logic tdo_data,
  output logic boot_pin_in,
  output logic rst_pad_in,
  output logic tdo_pin
);
  // ==========================================================
  // Pad levels
  // ==========================================================
  // Strong board pull-up beats the weak internal pull-down
  assign boot_pin_in = alt_strap |
    (boot_cfg.pull_en & boot_cfg.pull_up);
  assign rst_pad_in = rst_pad_cfg.oe ? rst_pad_cfg.out : 1'b1;
  // External pull-up keeps the unpulled pad from floating
  assign tdo_pin = tdo_cfg.oe ? tdo_data : 1'b1;
endmodule

`default_nettype wire

// *** prsc_properties.sv ***
/*
  Port checker for the pad reset and standby block.
  Assumes it is bound to prsc_top and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none

module prsc_properties #(
  parameter int NUM_GP = 8,
  parameter int NUM_WK = 4,
  parameter int NUM_TRACE = 4,
  parameter int RC_DIV = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic power_up_done,
  input wire logic phase2_done,
  input wire logic standby_req,
  input wire logic phase3_done,
  input wire prsc_pkg::prsc_pad_cfg_t boot_cfg,
  input wire prsc_pkg::prsc_pad_cfg_t rst_pad_cfg,
  input wire prsc_pkg::prsc_pad_cfg_t [NUM_TRACE-1:0] trace_cfg,
  input wire prsc_pkg::prsc_pad_cfg_t tdo_cfg,
  input wire prsc_pkg::prsc_pad_cfg_t [NUM_GP-1:0] gp_cfg,
  input wire logic [NUM_WK-1:0] wku_ibe,
  input wire logic [NUM_WK-1:0] wku_pull_en,
  input wire prsc_pkg::prsc_pad_cfg_t [NUM_WK-1:0] wk_cfg
);
  // ==========================================================
  // Helper state
  // ==========================================================
  logic pu_q;
  logic p2_q;
  logic [15:0] cnt_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pu_q <= 1'b0;
      p2_q <= 1'b0;
      cnt_q <= 16'h0000;
    end
    else
    begin
      pu_q <= pu_q | power_up_done;
      p2_q <= p2_q | (pu_q & phase2_done);
      if (p2_q && !phase3_done)
      begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================================
  // Assertions
  // ==========================================================
  a_powerup_tristate: assert property (
    !pu_q |-> boot_cfg == '0 && rst_pad_cfg == '0 && tdo_cfg == '0 &&
      trace_cfg == '0 && gp_cfg == '0 && wk_cfg == '0)
    else $error("pad not tristate in power-up");
  a_boot_pulldown: assert property (
    $past(pu_q) |-> boot_cfg == prsc_pkg::PAD_IN_PULLDOWN)
    else $error("boot pad not pulled down");
  a_rst_drive_low: assert property (
    $past(pu_q) && !phase3_done |-> rst_pad_cfg == prsc_pkg::PAD_DRIVE_LOW)
    else $error("reset pad not driven low");
  a_rst_pullup: assert property (
    phase3_done |-> rst_pad_cfg == prsc_pkg::PAD_IN_PULLUP)
    else $error("reset pad not pulled-up input");
  a_phase3_len: assert property (
    $rose(phase3_done) |-> cnt_q >= prsc_pkg::PHASE3_RC_CYCLES * RC_DIV)
    else $error("phase 3 too short");
  a_phase3_sticky: assert property (!$fell(phase3_done))
    else $error("phase3_done dropped");
  a_tdo_standby: assert property (
    standby_req [*3] |-> tdo_cfg == prsc_pkg::PAD_IN_NOPULL)
    else $error("tdo pad wrong in standby");
  a_gp_restore: assert property (
    $fell(standby_req) |-> ##[1:3] (gp_cfg[0] == prsc_pkg::PAD_TRISTATE_MED &&
      gp_cfg[2] == prsc_pkg::PAD_IN_PULLUP))
    else $error("general pads not restored");
  a_wk_restore: assert property (
    $fell(standby_req) |-> ##[1:3] (wk_cfg[1].ibe == wku_ibe[1] &&
      wk_cfg[1].pull_en == wku_pull_en[1]))
    else $error("wake pad not loaded");
  a_pready_wait: assert property (
    psel && penable && !$past(penable) |=> pready ##1 !pready)
    else $error("pready timing wrong");
  for (genvar i = 0; i < NUM_TRACE; i++)
  begin : g_tr
    a_trace_output: assert property ($past(pu_q) |-> trace_cfg[i].oe)
      else $error("trace pad not output");
  end
endmodule

bind prsc_top prsc_properties #(
  .NUM_GP(NUM_GP),
  .NUM_WK(NUM_WK),
  .NUM_TRACE(NUM_TRACE),
  .RC_DIV(RC_DIV)
) prsc_chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .power_up_done(power_up_done),
  .phase2_done(phase2_done), .standby_req(standby_req),
  .phase3_done(phase3_done), .boot_cfg(boot_cfg),
  .rst_pad_cfg(rst_pad_cfg), .trace_cfg(trace_cfg), .tdo_cfg(tdo_cfg),
  .gp_cfg(gp_cfg), .wku_ibe(wku_ibe), .wku_pull_en(wku_pull_en),
  .wk_cfg(wk_cfg));

`default_nettype wire

// *** pad_reset_standby_config_tb.sv ***
/*
  Self-checking bench: reset phases, APB registers, standby and wake.
  Assumes prsc_top, the board model and the bound checker.
*/
`timescale 1ns/100ps
`default_nettype none

module pad_reset_standby_config_tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pslverr, pready, pud = 1'b0, p2d = 1'b0;
  logic sby = 1'b0, p3d, boot_in, boot_alt, rst_in, tdo_pin, wake_req;
  logic strap = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] wibe = 4'h0, wpe = 4'h0, wpin = 4'h0;
  prsc_pkg::prsc_pad_cfg_t boot_cfg, rst_cfg, tdo_cfg;
  prsc_pkg::prsc_pad_cfg_t [3:0] tr_cfg, wk_cfg;
  prsc_pkg::prsc_pad_cfg_t [7:0] gp_cfg;
  int failures = 0, checks = 0, n;
  logic err;

  initial forever #5 pclk = ~pclk;

  prsc_top #(.RC_DIV(2)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_up_done(pud), .phase2_done(p2d), .standby_req(sby),
    .phase3_done(p3d), .boot_pin_in(boot_in), .boot_cfg(boot_cfg),
    .boot_alt(boot_alt), .rst_pad_in(rst_in), .rst_pad_cfg(rst_cfg),
    .trace_data(4'h5), .trace_cfg(tr_cfg), .tdo_data(1'b0),
    .tdo_cfg(tdo_cfg), .gp_cfg(gp_cfg), .wku_ibe(wibe),
    .wku_pull_en(wpe), .wake_pin(wpin), .wk_cfg(wk_cfg),
    .wake_req(wake_req));

  prsc_board board_u (.alt_strap(strap), .boot_cfg(boot_cfg),
    .rst_pad_cfg(rst_cfg), .tdo_cfg(tdo_cfg), .tdo_data(1'b0),
    .boot_pin_in(boot_in), .rst_pad_in(rst_in), .tdo_pin(tdo_pin));

  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic cmp(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  // Values read right after the edge are those the edge sampled
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1)
      failures++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wt(input int c);
    repeat (c) @(posedge pclk);
  endtask

  task automatic end_sim();
    if (failures == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    #200000;
    failures++;
    end_sim();
  end

  // ==========================================================
  // Tests
  // ==========================================================
  initial
  begin
    wt(16);
    presetn <= 1'b1;
    apb(1'b0, 12'h010, 32'h0);
    cmp("gp0 reset", 32'h20, rd);
    apb(1'b0, 12'h014, 32'h0);
    cmp("gp1 reset", 32'h0e, rd);
    apb(1'b0, 12'h024, 32'h0);
    cmp("gp5 reset", 32'h00, rd);
    apb(1'b0, 12'h0fc, 32'h0);
    cmp("unmapped", 32'h1, {31'h0, err});
    cmp("gp1 early", 32'h0, gp_cfg[1]);
    pud <= 1'b1;
    wt(3);
    cmp("boot", 32'h06, boot_cfg);
    cmp("rst low", 32'h01, rst_cfg);
    cmp("gp4", 32'h0e, gp_cfg[4]);
    cmp("gp0", 32'h20, gp_cfg[0]);
    cmp("gp7", 32'h00, gp_cfg[7]);
    cmp("trace", 32'h3, {tr_cfg[3].oe, tr_cfg[2].out});
    p2d <= 1'b1;
    wt(1);
    p2d <= 1'b0;
    n = 0;
    while (p3d !== 1'b1 && n < 1000)
    begin
      wt(1);
      n++;
    end
    cmp("phase3 len", 32'h1, {31'h0, n >= 80 && n <= 90});
    cmp("rst pullup", 32'h0e, rst_cfg);
    apb(1'b0, 12'h000, 32'h0);
    cmp("status", 32'h63, rd);
    apb(1'b1, 12'h018, 32'h01);
    apb(1'b1, 12'h004, 32'h0f);
    wibe <= 4'ha;
    wpe <= 4'h6;
    wpin <= 4'h1;
    wt(5);
    cmp("wake run", 32'h1, {31'h0, wake_req});
    sby <= 1'b1;
    wt(6);
    cmp("wake sby", 32'h0, {31'h0, wake_req});
    cmp("tdo sby", 32'h02, tdo_cfg);
    cmp("tdo pin", 32'h1, {31'h0, tdo_pin});
    cmp("wk3 joint", 32'h2, {wk_cfg[3].ibe, wk_cfg[3].pull_en});
    wpin <= 4'h4;
    wt(5);
    cmp("wake pin2", 32'h1, {31'h0, wake_req});
    wpin <= 4'h0;
    sby <= 1'b0;
    wt(4);
    cmp("gp2 back", 32'h0e, gp_cfg[2]);
    cmp("wk1", 32'h3, {wk_cfg[1].ibe, wk_cfg[1].pull_en});
    cmp("wk0", 32'h0, {wk_cfg[0].ibe, wk_cfg[0].pull_en});
    // Second reset with the board strap fitted: alternate boot caught
    presetn <= 1'h0;
    pud <= 1'h0;
    strap <= 1'h1;
    wt(16);
    presetn <= 1'h1;
    wt(3);
    pud <= 1'h1;
    wt(4);
    apb(1'b0, 12'h000, 32'h0);
    cmp("status alt", 32'h11, rd);
    cmp("boot alt", 32'h1, {31'h0, boot_alt});
    end_sim();
  end
endmodule

`default_nettype wire
